// >>> hdl/wsm_top.sv
// Weather sensor monitoring: wind fault timeouts, threshold values, gates, telegrams
`timescale 1ns/100ps
`include "wsm_cfg.svh"
module wsm_top #(
    parameter int SEC_CYCLES = `WSM_SEC_NS / `WSM_CLK_PERIOD_NS
) (
    // Clock and reset
    input logic clk,
    input logic sys_rst,
    // Sensor samples from same-clock logic
    input logic [`WSM_WIND_W-1:0] wind_speed,
    input logic wind_stb,
    input logic signed [`WSM_TEMP_W-1:0] temp_val,
    input logic temp_stb,
    // Asynchronous pins
    input logic rain_pin,
    input logic heater_pin,
    // External one-bit values for the gates
    input logic wind_lv_in,
    input logic ext_lv_in,
    // Configuration
    input logic [`WSM_CNT_W-1:0] const_wind_min,
    input logic [`WSM_CNT_W-1:0] zero_wind_hr,
    input logic temp_lv_two,
    input wsm_pkg::wsm_temp_cfg_t temp_cfg [`WSM_NUM_LV],
    input logic rain_lv_two,
    input logic [`WSM_CNT_W-1:0] rain_delay_min [`WSM_NUM_LV],
    input wsm_pkg::wsm_gate_cfg_t gate_cfg [`WSM_NUM_GATES],
    input logic [`WSM_NUM_OBJ-1:0] read_en,
    // Read requests
    input logic rd_req,
    input logic [`WSM_ID_W-1:0] rd_id,
    // Object values and telegrams
    output logic [`WSM_NUM_OBJ-1:0] obj_q,
    output logic tx_valid_q,
    output wsm_pkg::wsm_tx_t tx_q,
    output logic rd_ack_q,
    output logic rd_nak_q,
    output logic rd_val_q
);
    localparam int TW = `WSM_TEMP_W;
    localparam int HW = `WSM_HYST_W;
    localparam int NO = `WSM_NUM_OBJ;
    localparam logic [31:0] SEC_LAST = 32'(SEC_CYCLES - 1);
    localparam logic [7:0] MIN_LAST = 8'(`WSM_SEC_PER_MIN - 1);
    localparam logic [7:0] HR_LAST = 8'(`WSM_MIN_PER_HOUR - 1);

    // Elaboration check on the second divider
    if (SEC_CYCLES < 1) begin : g_chk
        $error("wsm_top: SEC_CYCLES must be at least 1");
    end

    // Time base: second counter, minute and hour enable pulses
    logic [31:0] sec_cnt_q, sec_cnt_d;
    logic [7:0] s_of_m_q, s_of_m_d, m_of_h_q, m_of_h_d;
    logic min_tick_q, min_tick_d, hr_tick_q, hr_tick_d;
    always_comb begin
        sec_cnt_d = sec_cnt_q + 32'h1;
        s_of_m_d = s_of_m_q;
        m_of_h_d = m_of_h_q;
        min_tick_d = 1'b0;
        hr_tick_d = 1'b0;
        if (sec_cnt_q == SEC_LAST) begin
            sec_cnt_d = 32'h0;
            s_of_m_d = s_of_m_q + 8'h1;
            if (s_of_m_q == MIN_LAST) begin
                s_of_m_d = 8'h0;
                min_tick_d = 1'b1;
                m_of_h_d = m_of_h_q + 8'h1;
                if (m_of_h_q == HR_LAST) begin
                    m_of_h_d = 8'h0;
                    hr_tick_d = 1'b1;
                end
            end
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sec_cnt_q <= 32'h0;
            s_of_m_q <= 8'h0;
            m_of_h_q <= 8'h0;
            min_tick_q <= 1'b0;
            hr_tick_q <= 1'b0;
        end else begin
            sec_cnt_q <= sec_cnt_d;
            s_of_m_q <= s_of_m_d;
            m_of_h_q <= m_of_h_d;
            min_tick_q <= min_tick_d;
            hr_tick_q <= hr_tick_d;
        end
    end

    // Pin synchronisers; a change counts once stages two and three agree
    logic [`WSM_SYNC_STAGES-1:0] rain_s_q, rain_s_d, heat_s_q, heat_s_d;
    logic rain_q, rain_d, heater_q, heater_d;
    always_comb begin
        rain_s_d = {rain_s_q[1:0], rain_pin};
        heat_s_d = {heat_s_q[1:0], heater_pin};
        rain_d = (rain_s_q[1] == rain_s_q[2]) ? rain_s_q[2] : rain_q;
        heater_d = (heat_s_q[1] == heat_s_q[2]) ? heat_s_q[2] : heater_q;
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rain_s_q <= '0;
            heat_s_q <= '0;
            rain_q <= 1'b0;
            heater_q <= 1'b0;
        end else begin
            rain_s_q <= rain_s_d;
            heat_s_q <= heat_s_d;
            rain_q <= rain_d;
            heater_q <= heater_d;
        end
    end

    // Wind monitors: minutes unchanged, hours at zero
    logic [`WSM_WIND_W-1:0] wind_prev_q, wind_prev_d;
    logic [`WSM_CNT_W-1:0] const_cnt_q, const_cnt_d, zero_cnt_q, zero_cnt_d;
    logic wind_chg, const_flt, zero_flt;
    always_comb begin
        wind_chg = wind_stb && (wind_speed != wind_prev_q);
        wind_prev_d = wind_stb ? wind_speed : wind_prev_q;
        const_cnt_d = const_cnt_q;
        zero_cnt_d = zero_cnt_q;
        if (wind_chg) begin
            const_cnt_d = '0;
        end else if (min_tick_q && const_cnt_q != '1) begin
            const_cnt_d = const_cnt_q + 1'b1;
        end
        if (wind_stb && wind_speed != '0) begin
            zero_cnt_d = '0;
        end else if (hr_tick_q && zero_cnt_q != '1) begin
            zero_cnt_d = zero_cnt_q + 1'b1;
        end
        const_flt = (const_wind_min != '0) && (const_cnt_q > const_wind_min);
        zero_flt = (zero_wind_hr != '0) && (zero_cnt_q > zero_wind_hr);
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wind_prev_q <= '0;
            const_cnt_q <= '0;
            zero_cnt_q <= '0;
        end else begin
            wind_prev_q <= wind_prev_d;
            const_cnt_q <= const_cnt_d;
            zero_cnt_q <= zero_cnt_d;
        end
    end

    // Threshold values for temperature and precipitation
    logic [`WSM_NUM_LV-1:0] tlv_q, tlv_d, rlv_q, rlv_d, lv_en_t, lv_en_r;
    logic [`WSM_CNT_W-1:0] rcnt_q [`WSM_NUM_LV];
    logic [`WSM_CNT_W-1:0] rcnt_d [`WSM_NUM_LV];
    logic signed [TW:0] t_x, lim_x [`WSM_NUM_LV], hi_x [`WSM_NUM_LV], lo_x [`WSM_NUM_LV];
    always_comb begin
        // first value always, second on request
        lv_en_t = {temp_lv_two, 1'b1};
        lv_en_r = {rain_lv_two, 1'b1};
        t_x = {temp_val[TW-1], temp_val};
        for (int i = 0; i < `WSM_NUM_LV; i++) begin
            lim_x[i] = {temp_cfg[i].limit[TW-1], temp_cfg[i].limit};
            hi_x[i] = lim_x[i] + $signed({{(TW + 1 - HW){1'b0}}, temp_cfg[i].hyst});
            lo_x[i] = lim_x[i] - $signed({{(TW + 1 - HW){1'b0}}, temp_cfg[i].hyst});
            tlv_d[i] = tlv_q[i];
            if (!lv_en_t[i]) begin
                tlv_d[i] = 1'b0;
            end else if (temp_stb && !temp_cfg[i].overshoot) begin
                if (t_x < lim_x[i]) begin
                    tlv_d[i] = 1'b1;
                end else if (t_x > hi_x[i]) begin
                    tlv_d[i] = 1'b0;
                end
            end else if (temp_stb) begin
                if (t_x > lim_x[i]) begin
                    tlv_d[i] = 1'b1;
                end else if (t_x < lo_x[i]) begin
                    tlv_d[i] = 1'b0;
                end
            end
            rcnt_d[i] = rcnt_q[i];
            rlv_d[i] = rlv_q[i];
            if (!rain_q || !lv_en_r[i]) begin
                rcnt_d[i] = '0;
                rlv_d[i] = 1'b0;
            end else if (!rlv_q[i]) begin
                if (rcnt_q[i] >= rain_delay_min[i]) begin
                    rlv_d[i] = 1'b1;
                end else if (min_tick_q) begin
                    rcnt_d[i] = rcnt_q[i] + 1'b1;
                end
            end
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tlv_q <= '0;
            rlv_q <= '0;
            for (int i = 0; i < `WSM_NUM_LV; i++) begin
                rcnt_q[i] <= '0;
            end
        end else begin
            tlv_q <= tlv_d;
            rlv_q <= rlv_d;
            for (int i = 0; i < `WSM_NUM_LV; i++) begin
                rcnt_q[i] <= rcnt_d[i];
            end
        end
    end

    // objects 0 to 6, wind value and external value as sources
    logic [`WSM_NUM_SRC-1:0] gate_src;
    logic [`WSM_NUM_GATES-1:0] gate_y;
    assign gate_src = {ext_lv_in, wind_lv_in, obj_q[`WSM_OBJ_GATE0-1:0]};
    for (genvar g = 0; g < `WSM_NUM_GATES; g++) begin : g_gate
        wsm_gate #(
            .NSRC(`WSM_NUM_SRC)
        ) u_gate (
            .cfg(gate_cfg[g]),
            .src(gate_src),
            .y(gate_y[g])
        );
    end

    // Object vector, pending telegrams and read answers
    logic [NO-1:0] obj_d, pend_q, pend_d, pval_q, pval_d, set, clr;
    logic tx_valid_d, rd_ack_d, rd_nak_d, rd_val_d;
    wsm_pkg::wsm_tx_t tx_d;
    logic [15:0] ren_x, obj_x;
    always_comb begin
        obj_d = {gate_y, rlv_q, tlv_q, heater_q, zero_flt, const_flt};
        // each change of objects 0 to 6 queues a one-bit telegram
        set = obj_d ^ obj_q;
        // gates send only their configured edge
        for (int g = 0; g < `WSM_NUM_GATES; g++) begin
            if (obj_d[`WSM_OBJ_GATE0 + g] ? !gate_cfg[g].tx_on : !gate_cfg[g].tx_off) begin
                set[`WSM_OBJ_GATE0 + g] = 1'b0;
            end
        end
        clr = '0;
        tx_valid_d = 1'b0;
        tx_d = '0;
        for (int i = NO - 1; i >= 0; i--) begin
            if (pend_q[i]) begin
                clr = NO'(1) << i;
                tx_valid_d = 1'b1;
                tx_d.id = `WSM_ID_W'(i);
                tx_d.val = pval_q[i];
            end
        end
        // New change wins over the clear of a sent one
        pend_d = (pend_q & ~clr) | set;
        pval_d = (pval_q & ~set) | (obj_d & set);
        ren_x = 16'(read_en);
        obj_x = 16'(obj_q);
        // read only with read flag set
        rd_ack_d = rd_req && ren_x[rd_id];
        rd_nak_d = rd_req && !ren_x[rd_id];
        rd_val_d = rd_ack_d ? obj_x[rd_id] : rd_val_q;
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            obj_q <= '0;
            pend_q <= '0;
            pval_q <= '0;
            tx_valid_q <= 1'b0;
            tx_q <= '0;
            rd_ack_q <= 1'b0;
            rd_nak_q <= 1'b0;
            rd_val_q <= 1'b0;
        end else begin
            obj_q <= obj_d;
            pend_q <= pend_d;
            pval_q <= pval_d;
            tx_valid_q <= tx_valid_d;
            tx_q <= tx_d;
            rd_ack_q <= rd_ack_d;
            rd_nak_q <= rd_nak_d;
            rd_val_q <= rd_val_d;
        end
    end

    // Assertions
    const_fault_set_a: assert property (@(posedge clk) disable iff (sys_rst)
        (const_wind_min != '0 && const_cnt_q > const_wind_min && !wind_chg) |=> obj_q[`WSM_OBJ_CONST])
        else $error("constant wind fault not raised");
    zero_fault_set_a: assert property (@(posedge clk) disable iff (sys_rst)
        (zero_wind_hr != '0 && zero_cnt_q > zero_wind_hr) |=> obj_q[`WSM_OBJ_ZERO])
        else $error("zero wind fault not raised");
    heater_status_a: assert property (@(posedge clk) disable iff (sys_rst)
        (heat_s_q[1] == heat_s_q[2]) |-> ##2 obj_q[`WSM_OBJ_HEAT] == $past(heat_s_q[2], 2))
        else $error("heater status does not follow pin");
    tx_pending_a: assert property (@(posedge clk) disable iff (sys_rst)
        tx_valid_q |-> (($past(pend_q) >> tx_q.id) & NO'(1)) != '0)
        else $error("telegram sent without pending change");
    read_refuse_a: assert property (@(posedge clk) disable iff (sys_rst)
        (rd_req && !ren_x[rd_id]) |=> (rd_nak_q && !rd_ack_q))
        else $error("read answered without read flag");
    temp_under_a: assert property (@(posedge clk) disable iff (sys_rst)
        (temp_stb && !temp_cfg[0].overshoot && t_x < lim_x[0]) |-> ##2 obj_q[`WSM_OBJ_TLV0])
        else $error("undershoot threshold not switched on");
    rain_off_a: assert property (@(posedge clk) disable iff (sys_rst)
        !rain_q |-> ##2 !obj_q[`WSM_OBJ_RLV0])
        else $error("rain threshold on without rain");
    gate_off_mute_a: assert property (@(posedge clk) disable iff (sys_rst)
        (tx_valid_q && tx_q.id == `WSM_ID_W'(`WSM_OBJ_GATE0) && !tx_q.val) |-> $past(gate_cfg[0].tx_off, 2))
        else $error("suppressed off telegram sent");
    wind_restart_a: assert property (@(posedge clk) disable iff (sys_rst)
        wind_chg |-> ##2 !obj_q[`WSM_OBJ_CONST])
        else $error("constant wind fault kept after change");
endmodule : wsm_top

// >>> hdl/wsm_cfg.svh
// Constants for the weather sensor monitoring block
`ifndef WSM_CFG_SVH
`define WSM_CFG_SVH
// Clock and time base
`define WSM_CLK_PERIOD_NS 5
`define WSM_SEC_NS 1000000000
`define WSM_SEC_PER_MIN 60
`define WSM_MIN_PER_HOUR 60
// Widths
`define WSM_WIND_W 8
`define WSM_TEMP_W 12
`define WSM_HYST_W 8
`define WSM_CNT_W 8
`define WSM_ID_W 4
`define WSM_SYNC_STAGES 3
// Object and source counts
`define WSM_NUM_GATES 6
`define WSM_NUM_SRC 9
`define WSM_NUM_OBJ 13
`define WSM_NUM_LV 2
// Object positions in the object vector
`define WSM_OBJ_CONST 0
`define WSM_OBJ_ZERO 1
`define WSM_OBJ_HEAT 2
`define WSM_OBJ_TLV0 3
`define WSM_OBJ_RLV0 5
`define WSM_OBJ_GATE0 7
// Gate source positions beyond the objects
`define WSM_SRC_WIND_LV 7
`define WSM_SRC_EXT 8
`endif

// >>> hdl/wsm_pkg.sv
// Types shared by the weather sensor monitoring block
`include "wsm_cfg.svh"
package wsm_pkg;
    // Logic gate configuration
    typedef struct packed {
        logic op_or;
        logic [`WSM_NUM_SRC-1:0] src_en;
        logic [`WSM_NUM_SRC-1:0] src_inv;
        logic tx_on;
        logic tx_off;
    } wsm_gate_cfg_t;
    // Temperature threshold_value configuration
    typedef struct packed {
        logic overshoot;
        logic [`WSM_TEMP_W-1:0] limit;
        logic [`WSM_HYST_W-1:0] hyst;
    } wsm_temp_cfg_t;
    // One-bit object telegram
    typedef struct packed {
        logic [`WSM_ID_W-1:0] id;
        logic val;
    } wsm_tx_t;
endpackage : wsm_pkg

// >>> hdl/wsm_gate.sv
// Configurable AND/OR logic gate over object and external one-bit sources
`timescale 1ns/100ps
`include "wsm_cfg.svh"
module wsm_gate #(
    parameter int NSRC = `WSM_NUM_SRC
) (
    // Configuration
    input wsm_pkg::wsm_gate_cfg_t cfg,
    // Sources and result
    input logic [NSRC-1:0] src,
    output logic y
);
    logic [NSRC-1:0] eff;

    // Elaboration check on source count
    if (NSRC < 1 || NSRC > `WSM_NUM_SRC) begin : g_chk
        $error("wsm_gate: NSRC out of range");
    end

    // Per-input inversion, then AND or OR over enabled inputs
    always_comb begin
        eff = src ^ cfg.src_inv[NSRC-1:0];
        if (cfg.src_en[NSRC-1:0] == '0) begin
            y = 1'b0;
        end else if (cfg.op_or) begin
            y = |(eff & cfg.src_en[NSRC-1:0]);
        end else begin
            y = &(eff | ~cfg.src_en[NSRC-1:0]);
        end
    end
endmodule : wsm_gate

// >>> testbench/wsm_bus_model.sv
// Field bus receiver model that logs every one-bit telegram per object
`timescale 1ns/100ps
`include "wsm_cfg.svh"
module wsm_bus_model (
    // Clock and reset
    input logic clk,
    input logic sys_rst,
    // Telegram stream from the device
    input logic tx_valid_q,
    input wsm_pkg::wsm_tx_t tx_q,
    // Last value and telegram count per object
    output logic [15:0] last_val,
    output logic [15:0][7:0] tx_cnt
);
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            last_val <= 16'h0000;
            tx_cnt <= '0;
        end else if (tx_valid_q) begin
            last_val[tx_q.id] <= tx_q.val;
            tx_cnt[tx_q.id] <= tx_cnt[tx_q.id] + 8'h01;
        end
    end
endmodule : wsm_bus_model

// >>> testbench/test_weather_sensor_monitoring.sv
// Self-checking bench for the weather sensor monitoring block
`timescale 1ns/100ps
`include "wsm_cfg.svh"
module test_weather_sensor_monitoring;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] wind_speed = 8'h00;
    logic wind_stb = 1'b0;
    logic signed [11:0] temp_val = 12'h014;
    logic temp_stb = 1'b0;
    logic rain_pin = 1'b0;
    logic heater_pin = 1'b0;
    logic wind_lv_in = 1'b0;
    logic ext_lv_in = 1'b0;
    logic [7:0] const_wind_min = 8'h02;
    logic [7:0] zero_wind_hr = 8'h01;
    logic temp_lv_two = 1'b0;
    wsm_pkg::wsm_temp_cfg_t temp_cfg [`WSM_NUM_LV];
    logic rain_lv_two = 1'b1;
    logic [7:0] rain_delay_min [`WSM_NUM_LV];
    wsm_pkg::wsm_gate_cfg_t gate_cfg [`WSM_NUM_GATES];
    logic [12:0] read_en = 13'h0004;
    logic rd_req = 1'b0;
    logic [3:0] rd_id = 4'h0;
    logic [12:0] obj_q;
    logic tx_valid_q;
    wsm_pkg::wsm_tx_t tx_q;
    logic rd_ack_q;
    logic rd_nak_q;
    logic rd_val_q;
    logic [15:0] last_val;
    logic [15:0][7:0] tx_cnt;
    int n_mismatch = 0;
    int checks = 0;
    // Configuration: anti-icing activation, deactivation and wind OR gate
    initial begin
        temp_cfg[0] = '{overshoot: 1'h0, limit: 12'h003, hyst: 8'h02};
        temp_cfg[1] = '{overshoot: 1'h1, limit: 12'h00A, hyst: 8'h02};
        rain_delay_min[0] = 8'h00;
        rain_delay_min[1] = 8'h01;
        gate_cfg[0] = '{op_or: 1'h0, src_en: 9'h028, src_inv: 9'h000, tx_on: 1'h1, tx_off: 1'h0};
        gate_cfg[1] = '{op_or: 1'h0, src_en: 9'h008, src_inv: 9'h000, tx_on: 1'h0, tx_off: 1'h1};
        gate_cfg[2] = '{op_or: 1'h1, src_en: 9'h183, src_inv: 9'h000, tx_on: 1'h1, tx_off: 1'h1};
        // Gate 3 passes the inverted heater status
        gate_cfg[3] = '{op_or: 1'h0, src_en: 9'h004, src_inv: 9'h004, tx_on: 1'h1, tx_off: 1'h1};
        for (int i = 4; i < 6; i++) begin
            gate_cfg[i] = '{op_or: 1'h0, src_en: 9'h000, src_inv: 9'h000, tx_on: 1'h1, tx_off: 1'h1};
        end
    end
    // 200 MHz clock
    initial begin
        forever #2.5 clk = ~clk;
    end
    wsm_top #(.SEC_CYCLES(4)) u_wsm_top (
        .clk(clk), .sys_rst(sys_rst), .wind_speed(wind_speed), .wind_stb(wind_stb),
        .temp_val(temp_val), .temp_stb(temp_stb), .rain_pin(rain_pin), .heater_pin(heater_pin),
        .wind_lv_in(wind_lv_in), .ext_lv_in(ext_lv_in), .const_wind_min(const_wind_min),
        .zero_wind_hr(zero_wind_hr), .temp_lv_two(temp_lv_two), .temp_cfg(temp_cfg),
        .rain_lv_two(rain_lv_two), .rain_delay_min(rain_delay_min), .gate_cfg(gate_cfg),
        .read_en(read_en), .rd_req(rd_req), .rd_id(rd_id), .obj_q(obj_q), .tx_valid_q(tx_valid_q),
        .tx_q(tx_q), .rd_ack_q(rd_ack_q), .rd_nak_q(rd_nak_q), .rd_val_q(rd_val_q));
    wsm_bus_model u_wsm_bus_model (
        .clk(clk), .sys_rst(sys_rst), .tx_valid_q(tx_valid_q), .tx_q(tx_q),
        .last_val(last_val), .tx_cnt(tx_cnt));
    // Compare and count
    task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    // One-cycle wind or temperature sample
    task automatic put_wind(input logic [7:0] v);
        @(negedge clk);
        wind_speed = v;
        wind_stb = 1'b1;
        @(negedge clk);
        wind_stb = 1'b0;
        cyc(4);
    endtask : put_wind
    task automatic put_temp(input logic [11:0] v);
        @(negedge clk);
        temp_val = v;
        temp_stb = 1'b1;
        @(negedge clk);
        temp_stb = 1'b0;
        cyc(4);
    endtask : put_temp
    // Object read: ack, nak and value
    task automatic rd(input logic [3:0] id, input logic [2:0] exp);
        @(negedge clk);
        rd_req = 1'b1;
        rd_id = id;
        @(negedge clk);
        rd_req = 1'b0;
        // Answer stands for the one cycle after the request edge
        check("read", {13'h0000, exp}, {13'h0000, rd_ack_q, rd_nak_q, rd_val_q});
    endtask : rd
    task automatic stop_test;
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test
    // Watchdog
    initial begin
        #300000;
        n_mismatch++;
        stop_test;
    end
    // Test sequence
    initial begin
        cyc(16);
        sys_rst = 1'b0;
        check("obj_reset", 16'h0000, {3'h0, obj_q});
        // Constant wind timeout and restart
        put_wind(8'h05);
        cyc(360);
        check("const_early", 16'h0000, obj_q[0]);
        cyc(400);
        check("const_fault", 16'h0001, obj_q[0]);
        check("wind_or", 16'h0001, obj_q[9]);
        check("inv_gate_on", 16'h0001, obj_q[10]);
        put_wind(8'h06);
        check("const_clear", 16'h0000, obj_q[0]);
        wind_lv_in = 1'b1;
        cyc(4);
        check("wind_lv_or", 16'h0001, obj_q[9]);
        wind_lv_in = 1'b0;
        ext_lv_in = 1'b1;
        cyc(4);
        check("ext_lv_or", 16'h0001, obj_q[9]);
        ext_lv_in = 1'b0;
        // Heater supply status, telegram and reads
        heater_pin = 1'b1;
        cyc(10);
        check("heater", 16'h0001, obj_q[2]);
        check("heater_tx", 16'h0001, last_val[2]);
        check("heater_cnt", 16'h0001, tx_cnt[2]);
        check("inv_gate_off", 16'h0000, obj_q[10]);
        rd(4'h2, 3'h5);
        // Refused reads keep the last answered value
        rd(4'h3, 3'h3);
        rd(4'hD, 3'h3);
        // Temperature below limit, gates and rain
        put_temp(12'h002);
        check("temp_on", 16'h0001, obj_q[3]);
        check("temp_two_off", 16'h0000, obj_q[4]);
        check("deact_no_on", 16'h0000, tx_cnt[8]);
        rain_pin = 1'b1;
        cyc(10);
        check("rain_on", 16'h0001, obj_q[5]);
        check("rain_delay", 16'h0000, obj_q[6]);
        check("act_gate", 16'h0001, obj_q[7]);
        check("act_tx", 16'h0001, last_val[7]);
        cyc(500);
        check("rain_delayed", 16'h0001, obj_q[6]);
        rain_pin = 1'b0;
        cyc(10);
        check("act_off", 16'h0000, obj_q[7]);
        check("act_no_off", 16'h0001, last_val[7]);
        put_temp(12'h004);
        check("temp_hyst", 16'h0001, obj_q[3]);
        put_temp(12'h006);
        check("temp_off", 16'h0000, obj_q[3]);
        check("deact_off", 16'h0001, tx_cnt[8]);
        temp_lv_two = 1'b1;
        put_temp(12'h00C);
        check("temp_two_on", 16'h0001, obj_q[4]);
        // Zero wind timeout and restart
        put_wind(8'h00);
        cyc(12960);
        check("zero_early", 16'h0000, obj_q[1]);
        cyc(16000);
        check("zero_fault", 16'h0001, obj_q[1]);
        put_wind(8'h07);
        check("zero_clear", 16'h0000, obj_q[1]);
        stop_test;
    end
endmodule : test_weather_sensor_monitoring
